// File: verilog/clkgen_pkg.sv
/*
  Shared constants and carrier types of the multi-mode clock generator:
  register offsets, field positions, reset values, source codes, modes.
  Assumes a byte-wide register port with a 4-bit word address.
*/
package clkgen_pkg;

    // ========================================================================
    // register offsets
    localparam logic [3:0] CLK_SEL_ADDR   = 4'h0;
    localparam logic [3:0] OSC_CTRL_ADDR  = 4'h1;
    localparam logic [3:0] LOOP_CTRL_ADDR = 4'h2;
    localparam logic [3:0] STATUS_ADDR    = 4'h3;

    // ========================================================================
    // field positions
    localparam int CS_SRC_HI   = 7;
    localparam int CS_SRC_LO   = 6;
    localparam int CS_REFERENCE_DIVIDER_HI  = 5;
    localparam int CS_REFERENCE_DIVIDER_LO  = 3;
    localparam int CS_IREF     = 2;
    localparam int OC_OUTPUT_BUS_DIVIDER_HI  = 7;
    localparam int OC_OUTPUT_BUS_DIVIDER_LO  = 6;
    localparam int OC_RANGE    = 5;
    localparam int OC_HGO      = 4;
    localparam int OC_LP       = 3;
    localparam int OC_EXT_REF_TYPE    = 2;
    localparam int OC_EREN     = 1;
    localparam int LC_LOOP_SELECT     = 6;
    localparam int LC_PLL_MULTIPLIER_HI  = 3;
    localparam int LC_PLL_MULTIPLIER_LO  = 0;
    localparam int ST_LOCK     = 6;
    localparam int ST_LOOP_SELECT_STATUS    = 5;
    localparam int ST_IREFST   = 4;
    localparam int ST_OUTPUT_SOURCE_STATUS_HI = 3;
    localparam int ST_OUTPUT_SOURCE_STATUS_LO = 2;
    localparam int ST_CRYSTAL_READY  = 1;

    // ========================================================================
    // reset values and codes
    localparam logic [7:0] CLK_SEL_RST   = 8'h04;
    localparam logic [7:0] OSC_CTRL_RST  = 8'h40;
    localparam logic [7:0] LOOP_CTRL_RST = 8'h00;
    localparam logic [7:0] STATUS_RST    = 8'h10;
    localparam logic [1:0] SEL_LOOP      = 2'h0;
    localparam logic [1:0] SEL_INT       = 2'h1;
    localparam logic [1:0] SEL_EXT       = 2'h2;
    localparam logic [1:0] ST_FLL        = 2'h0;
    localparam logic [1:0] ST_INT        = 2'h1;
    localparam logic [1:0] ST_EXT        = 2'h2;
    localparam logic [1:0] ST_PLL        = 2'h3;
    localparam logic [1:0] OUTPUT_BUS_DIVIDER_ONE      = 2'h0;

    typedef enum logic [2:0] {
        FLL_ENGAGED_INTERNAL,
        FLL_ENGAGED_EXTERNAL,
        FLL_BYPASSED_INTERNAL,
        FLL_BYPASSED_EXTERNAL,
        PLL_ENGAGED_EXTERNAL,
        PLL_BYPASSED_EXTERNAL,
        LOW_POWER_INTERNAL_BYPASS,
        LOW_POWER_EXTERNAL_BYPASS
    } mode_e;

    // controls toward the analog oscillator, loops and clock muxes
    typedef struct packed {
        logic       range_high;
        logic       high_gain;
        logic       crystal;
        logic       ext_enable;
        logic       fll_enable;
        logic       pll_enable;
        logic [2:0] ref_div;
        logic [3:0] pll_mult;
        logic       ref_internal;
        logic       loop_pll;
        logic [1:0] out_src;
    } osc_ctrl_s;

    localparam osc_ctrl_s CTRL_RST = '{range_high: 1'b0, high_gain: 1'b0, crystal: 1'b0,
                                       ext_enable: 1'b0, fll_enable: 1'b1, pll_enable: 1'b0,
                                       ref_div: 3'h0, pll_mult: 4'h0, ref_internal: 1'b1,
                                       loop_pll: 1'b0, out_src: 2'h0};

endpackage

// File: verilog/glitch_free_switch.sv
/*
  Model of one glitch-free clock multiplexer: the current selection follows
  the requested one only after the request has stood for SETTLE cycles.
  Assumes the request comes from logic on the same clock.
*/
`timescale 1ns/1ps
module glitch_free_switch #(
    parameter int               WIDTH     = 2,
    parameter int               SETTLE    = 4,
    parameter logic [WIDTH-1:0] RESET_SEL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] req,
    output logic      [WIDTH-1:0] cur
);

    localparam int            CW        = $clog2(SETTLE + 1);
    localparam logic [CW-1:0] SETTLE_M1 = CW'(SETTLE - 1);

    typedef struct packed {
        logic [WIDTH-1:0] cur;
        logic [WIDTH-1:0] pend;
        logic [CW-1:0]    cnt;
    } sw_state_s;

    localparam sw_state_s SW_RST = '{cur: RESET_SEL, pend: RESET_SEL, cnt: '0};

    sw_state_s s_ff;
    sw_state_s nxt_s;

    // ========================================================================
    // settle counter: a new request restarts the wait
    always_comb
    begin
        nxt_s = s_ff;
        if (req != s_ff.pend)
        begin
            nxt_s.pend = req;
            nxt_s.cnt  = '0;
        end
        else if (s_ff.pend != s_ff.cur)
        begin
            if (s_ff.cnt == SETTLE_M1)
            begin
                nxt_s.cur = s_ff.pend;
                nxt_s.cnt = '0;
            end
            else
            begin
                nxt_s.cnt = s_ff.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_ff <= SW_RST;
        else
            s_ff <= nxt_s;
    end

    assign cur = s_ff.cur;

    // ========================================================================
    // checks
    switch_settled_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_ff.cur != $past(s_ff.cur)) |-> (s_ff.cur == $past(s_ff.pend)) &&
                                         ($past(s_ff.cnt) == SETTLE_M1))
        else $error("mux selection changed before settling");

endmodule

// File: verilog/clock_generator.sv
/*
  Control and status logic of the multi-mode clock generator: three control
  registers, a status register, reference/loop/output clock mux sequencing,
  lock tracking, and the output and bus clock enables.
  Assumes analog oscillator, FLL and PLL outside; OSC_STABLE is asynchronous.
*/
// Chosen here: the placing of the registers and strobed register access.
// What this block does
// - output divider bits 7:6, zero means undivided
// - oscillator bit 5 selects high range
// - oscillator bit 4 sets high gain
// - oscillator bit 2 selects crystal reference
// - oscillator bit 1 keeps external reference on
// - crystal ready flag in status bit 1
// - select bits 7:6 pick output source
// - status bits 3:2 show actual source
// - select bits 5:3 set reference divider
// - select bit 2 picks loop reference
// - status bit 4 shows internal reference active
// - loop bit 6 picks PLL over FLL
// - loop bits 3:0 set PLL multiplier
// - status bit 5 shows PLL feeding loop
// - status bit 6 shows loop lock
// - low-power bypass disables loops, defers settings
// - leaving external low power picks bypass mode
// - FLL keeps running in FLL bypassed modes unless PLL is the selected loop
// - bus clock is output clock halved
// - low power from internal bypass enters low-power
// - reset enters FLL engaged internal, divide-by-two
`timescale 1ns/1ps
module clock_generator #(
    parameter int LOCK_CYCLES   = 1000,
    parameter int SWITCH_CYCLES = 4
) (
    input  wire logic                REF_CLK,
    input  wire logic                RSTN,
    input  wire logic [3:0]          ADDR,
    input  wire logic [7:0]          WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    input  wire logic                OSC_STABLE,
    output logic      [7:0]          RDATA,
    output clkgen_pkg::osc_ctrl_s    OSC_CTRL,
    output clkgen_pkg::mode_e        MODE,
    output logic                     GEN_CLK_EN,
    output logic                     BUS_CLK_EN
);

    localparam int               CNT_W   = $clog2(LOCK_CYCLES);
    localparam logic [CNT_W-1:0] LOCK_M1 = CNT_W'(LOCK_CYCLES - 1);

    typedef struct packed {
        logic [7:0]            cs;
        logic [7:0]            oc;
        logic [7:0]            lc;
        logic [7:0]            rdata;
        logic [7:0]            status;
        logic [2:0]            sync;
        logic                  xtal_stable;
        logic [2:0]            eff_reference_divider;
        logic [3:0]            eff_pll_multiplier;
        logic                  eff_loop_select;
        logic [8:0]            cfg_seen;
        logic [CNT_W-1:0]      lock_cnt;
        logic                  locked;
        logic [2:0]            gen_cnt;
        logic                  gen_tick;
        logic                  bus_phase;
        logic                  bus_tick;
        clkgen_pkg::mode_e     mode;
        clkgen_pkg::osc_ctrl_s ctrl;
    } gen_state_s;

    localparam gen_state_s GEN_RST = '{
        cs:          clkgen_pkg::CLK_SEL_RST,
        oc:          clkgen_pkg::OSC_CTRL_RST,
        lc:          clkgen_pkg::LOOP_CTRL_RST,
        rdata:       8'h00,
        status:      clkgen_pkg::STATUS_RST,
        sync:        3'h0,
        xtal_stable: 1'b0,
        eff_reference_divider:    clkgen_pkg::CLK_SEL_RST[clkgen_pkg::CS_REFERENCE_DIVIDER_HI:clkgen_pkg::CS_REFERENCE_DIVIDER_LO],
        eff_pll_multiplier:    clkgen_pkg::LOOP_CTRL_RST[clkgen_pkg::LC_PLL_MULTIPLIER_HI:clkgen_pkg::LC_PLL_MULTIPLIER_LO],
        eff_loop_select:    clkgen_pkg::LOOP_CTRL_RST[clkgen_pkg::LC_LOOP_SELECT],
        cfg_seen:    9'h000,
        lock_cnt:    '0,
        locked:      1'b0,
        gen_cnt:     3'h0,
        gen_tick:    1'b0,
        bus_phase:   1'b0,
        bus_tick:    1'b0,
        mode:        clkgen_pkg::FLL_ENGAGED_INTERNAL,
        ctrl:        clkgen_pkg::CTRL_RST
    };

    gen_state_s s_ff;
    gen_state_s nxt_s;

    logic [1:0] src_sel;
    logic       lp_now;
    logic       loops_on;
    logic       ref_cur;
    logic       loop_cur;
    logic [1:0] out_cur;
    logic [1:0] out_req;
    logic       ext_active;
    logic       crystal_ready;
    logic [8:0] cfg_now;

    // ========================================================================
    // helpers

    // last count of the output divider for a divider code
    function automatic logic [2:0] div_last(input logic [1:0] code);
        logic [3:0] span;
        span     = 4'h1 << code;
        div_last = 3'(span - 4'h1);
    endfunction

    // ========================================================================
    // mode decode from the control registers

    // low power is honoured only while a bypass source is selected
    assign src_sel  = s_ff.cs[clkgen_pkg::CS_SRC_HI:clkgen_pkg::CS_SRC_LO];
    assign lp_now   = s_ff.oc[clkgen_pkg::OC_LP] && (src_sel != clkgen_pkg::SEL_LOOP);
    assign loops_on = !lp_now;
    // output mux request: loop output, internal or external reference
    assign out_req = (src_sel == clkgen_pkg::SEL_LOOP) ?
                     (loop_cur ? clkgen_pkg::ST_PLL : clkgen_pkg::ST_FLL) :
                     ((src_sel == clkgen_pkg::SEL_EXT) ? clkgen_pkg::ST_EXT :
                      clkgen_pkg::ST_INT);
    // external reference runs when enabled or when anything uses it
    assign ext_active = s_ff.oc[clkgen_pkg::OC_EREN] || !ref_cur ||
                        (out_cur == clkgen_pkg::ST_EXT) ||
                        (src_sel == clkgen_pkg::SEL_EXT);
    // crystal ready only once the filtered startup indication is seen
    assign crystal_ready = s_ff.oc[clkgen_pkg::OC_EXT_REF_TYPE] && ext_active &&
                           s_ff.xtal_stable;
    // anything that makes the active loop lose lock
    assign cfg_now = {ref_cur, loop_cur, s_ff.eff_reference_divider, s_ff.eff_pll_multiplier};

    // ========================================================================
    // clock multiplexers

    // loop reference mux, internal after reset
    glitch_free_switch #(
        .WIDTH     (1),
        .SETTLE    (SWITCH_CYCLES),
        .RESET_SEL (1'b1)
    ) ref_mux (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .req   (s_ff.cs[clkgen_pkg::CS_IREF]),
        .cur   (ref_cur)
    );

    // loop output mux, follows the effective loop select
    glitch_free_switch #(
        .WIDTH     (1),
        .SETTLE    (SWITCH_CYCLES),
        .RESET_SEL (1'b0)
    ) loop_mux (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .req   (s_ff.eff_loop_select),
        .cur   (loop_cur)
    );

    // output clock mux
    glitch_free_switch #(
        .WIDTH     (2),
        .SETTLE    (SWITCH_CYCLES),
        .RESET_SEL (clkgen_pkg::ST_FLL)
    ) out_mux (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .req   (out_req),
        .cur   (out_cur)
    );

    // ========================================================================
    // next state
    always_comb
    begin
        nxt_s = s_ff;
        // register writes
        if (WR)
        begin
            case (ADDR)
                clkgen_pkg::CLK_SEL_ADDR:   nxt_s.cs = WDATA;
                clkgen_pkg::OSC_CTRL_ADDR:  nxt_s.oc = WDATA;
                clkgen_pkg::LOOP_CTRL_ADDR: nxt_s.lc = WDATA;
                default:                    nxt_s.cs = s_ff.cs;
            endcase
        end
        // read data stands only in the cycle after the strobe
        nxt_s.rdata = 8'h00;
        if (RD)
        begin
            case (ADDR)
                clkgen_pkg::CLK_SEL_ADDR:   nxt_s.rdata = s_ff.cs;
                clkgen_pkg::OSC_CTRL_ADDR:  nxt_s.rdata = s_ff.oc;
                clkgen_pkg::LOOP_CTRL_ADDR: nxt_s.rdata = s_ff.lc;
                clkgen_pkg::STATUS_ADDR:    nxt_s.rdata = s_ff.status;
                default:                    nxt_s.rdata = 8'h00;
            endcase
        end
        // startup indication: three stages, taken when the last two agree
        nxt_s.sync = {s_ff.sync[1:0], OSC_STABLE};
        if (s_ff.sync[1] == s_ff.sync[2])
            nxt_s.xtal_stable = s_ff.sync[2];
        // loop settings reach the loops only outside low power
        if (loops_on)
        begin
            nxt_s.eff_reference_divider = s_ff.cs[clkgen_pkg::CS_REFERENCE_DIVIDER_HI:clkgen_pkg::CS_REFERENCE_DIVIDER_LO];
            nxt_s.eff_pll_multiplier = s_ff.lc[clkgen_pkg::LC_PLL_MULTIPLIER_HI:clkgen_pkg::LC_PLL_MULTIPLIER_LO];
            nxt_s.eff_loop_select = s_ff.lc[clkgen_pkg::LC_LOOP_SELECT];
        end
        // lock: restart in low power or on any change of reference, loop select, divider or multiplier
        nxt_s.cfg_seen = cfg_now;
        if (!loops_on || (cfg_now != s_ff.cfg_seen))
        begin
            nxt_s.lock_cnt = '0;
            nxt_s.locked   = 1'b0;
        end
        else if (s_ff.lock_cnt == LOCK_M1)
        begin
            nxt_s.locked = 1'b1;
        end
        else
        begin
            nxt_s.lock_cnt = s_ff.lock_cnt + CNT_W'(1);
        end
        // generator output clock enable from the output divider
        nxt_s.gen_tick = 1'b0;
        if (s_ff.gen_cnt >= div_last(s_ff.oc[clkgen_pkg::OC_OUTPUT_BUS_DIVIDER_HI:clkgen_pkg::OC_OUTPUT_BUS_DIVIDER_LO]))
        begin
            nxt_s.gen_cnt  = 3'h0;
            nxt_s.gen_tick = 1'b1;
        end
        else
        begin
            nxt_s.gen_cnt = s_ff.gen_cnt + 3'h1;
        end
        // bus clock enable on every second generator tick
        nxt_s.bus_tick = nxt_s.gen_tick && s_ff.bus_phase;
        if (nxt_s.gen_tick)
            nxt_s.bus_phase = !s_ff.bus_phase;
        // mode from what the muxes really select
        case (out_cur)
            clkgen_pkg::ST_FLL:
                nxt_s.mode = ref_cur ? clkgen_pkg::FLL_ENGAGED_INTERNAL :
                             clkgen_pkg::FLL_ENGAGED_EXTERNAL;
            clkgen_pkg::ST_PLL:
                nxt_s.mode = clkgen_pkg::PLL_ENGAGED_EXTERNAL;
            clkgen_pkg::ST_INT:
                nxt_s.mode = lp_now ? clkgen_pkg::LOW_POWER_INTERNAL_BYPASS :
                             clkgen_pkg::FLL_BYPASSED_INTERNAL;
            default:
                nxt_s.mode = lp_now ? clkgen_pkg::LOW_POWER_EXTERNAL_BYPASS :
                             (loop_cur ? clkgen_pkg::PLL_BYPASSED_EXTERNAL :
                              clkgen_pkg::FLL_BYPASSED_EXTERNAL);
        endcase
        // controls toward oscillator, loops and muxes
        nxt_s.ctrl.range_high   = s_ff.oc[clkgen_pkg::OC_RANGE];
        nxt_s.ctrl.high_gain    = s_ff.oc[clkgen_pkg::OC_HGO];
        nxt_s.ctrl.crystal      = s_ff.oc[clkgen_pkg::OC_EXT_REF_TYPE];
        nxt_s.ctrl.ext_enable   = ext_active;
        nxt_s.ctrl.fll_enable   = loops_on && !loop_cur;
        nxt_s.ctrl.pll_enable   = loops_on && (loop_cur || s_ff.eff_loop_select);
        nxt_s.ctrl.ref_div      = s_ff.eff_reference_divider;
        nxt_s.ctrl.pll_mult     = s_ff.eff_pll_multiplier;
        nxt_s.ctrl.ref_internal = ref_cur;
        nxt_s.ctrl.loop_pll     = loop_cur;
        nxt_s.ctrl.out_src      = out_cur;
        // status shows completed switches only
        nxt_s.status                              = 8'h00;
        nxt_s.status[clkgen_pkg::ST_LOCK]         = s_ff.locked && loops_on;
        nxt_s.status[clkgen_pkg::ST_LOOP_SELECT_STATUS]        = loop_cur;
        nxt_s.status[clkgen_pkg::ST_IREFST]       = ref_cur;
        nxt_s.status[clkgen_pkg::ST_OUTPUT_SOURCE_STATUS_HI:clkgen_pkg::ST_OUTPUT_SOURCE_STATUS_LO] = out_cur;
        nxt_s.status[clkgen_pkg::ST_CRYSTAL_READY]      = crystal_ready;
    end

    // state register, reset state is fll engaged internal, divide-by-two
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            s_ff <= GEN_RST;
        else
            s_ff <= nxt_s;
    end

    // ========================================================================
    // outputs
    assign RDATA      = s_ff.rdata;
    assign OSC_CTRL   = s_ff.ctrl;
    assign MODE       = s_ff.mode;
    assign GEN_CLK_EN = s_ff.gen_tick;
    assign BUS_CLK_EN = s_ff.bus_tick;

    // ========================================================================
    // checks
    undivided_out_a: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        (s_ff.oc[clkgen_pkg::OC_OUTPUT_BUS_DIVIDER_HI:clkgen_pkg::OC_OUTPUT_BUS_DIVIDER_LO] == clkgen_pkg::OUTPUT_BUS_DIVIDER_ONE) &&
        ($past(s_ff.oc[clkgen_pkg::OC_OUTPUT_BUS_DIVIDER_HI:clkgen_pkg::OC_OUTPUT_BUS_DIVIDER_LO]) == clkgen_pkg::OUTPUT_BUS_DIVIDER_ONE)
        |=> GEN_CLK_EN)
        else $error("undivided output clock missed a cycle");
    osc_pins_a: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        $past(WR) && ($past(ADDR) == clkgen_pkg::OSC_CTRL_ADDR) |=>
        (OSC_CTRL.range_high == $past(WDATA[clkgen_pkg::OC_RANGE], 2)) &&
        (OSC_CTRL.high_gain == $past(WDATA[clkgen_pkg::OC_HGO], 2)) &&
        (OSC_CTRL.crystal == $past(WDATA[clkgen_pkg::OC_EXT_REF_TYPE], 2)))
        else $error("oscillator controls do not follow the write");
    ext_ref_kept_a: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        s_ff.status[clkgen_pkg::ST_CRYSTAL_READY] |-> OSC_CTRL.ext_enable && OSC_CTRL.crystal)
        else $error("crystal ready without a running crystal");
    source_status_a: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        ##1 (s_ff.status[clkgen_pkg::ST_OUTPUT_SOURCE_STATUS_HI:clkgen_pkg::ST_OUTPUT_SOURCE_STATUS_LO] == $past(out_cur)) &&
        (s_ff.status[clkgen_pkg::ST_IREFST] == $past(ref_cur)) &&
        (s_ff.status[clkgen_pkg::ST_LOOP_SELECT_STATUS] == $past(loop_cur)))
        else $error("status differs from mux selection");
    lp_hold_a: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        lp_now && $past(lp_now) |-> $stable(s_ff.eff_reference_divider) && $stable(s_ff.eff_pll_multiplier) &&
        $stable(s_ff.eff_loop_select) && !OSC_CTRL.fll_enable && !OSC_CTRL.pll_enable)
        else $error("loop settings moved in low power");
    lock_count_a: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        $rose(s_ff.status[clkgen_pkg::ST_LOCK]) |-> ($past(s_ff.lock_cnt, 2) == LOCK_M1))
        else $error("lock reported before the lock time");
    lp_clears_lock_a: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        !loops_on |=> !s_ff.status[clkgen_pkg::ST_LOCK])
        else $error("lock shown while loops are off");
    fll_bypass_on_a: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        (MODE == clkgen_pkg::FLL_BYPASSED_EXTERNAL) || (MODE == clkgen_pkg::FLL_BYPASSED_INTERNAL)
        |-> OSC_CTRL.fll_enable || OSC_CTRL.loop_pll)
        else $error("fll stopped in a bypassed mode");
    lp_exit_a: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        (MODE == clkgen_pkg::LOW_POWER_EXTERNAL_BYPASS) && !lp_now &&
        (out_cur == clkgen_pkg::ST_EXT) |=>
        (MODE == ($past(loop_cur) ? clkgen_pkg::PLL_BYPASSED_EXTERNAL :
                  clkgen_pkg::FLL_BYPASSED_EXTERNAL)))
        else $error("wrong bypass mode after low power exit");
    lp_enter_a: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        (MODE == clkgen_pkg::FLL_BYPASSED_INTERNAL) && lp_now &&
        (out_cur == clkgen_pkg::ST_INT) |=> (MODE == clkgen_pkg::LOW_POWER_INTERNAL_BYPASS))
        else $error("low power internal bypass not entered");
    bus_half_a: assert property (
        @(posedge REF_CLK) disable iff (!RSTN)
        BUS_CLK_EN |-> GEN_CLK_EN ##1 !BUS_CLK_EN ##[0:7] (GEN_CLK_EN && !BUS_CLK_EN))
        else $error("bus clock not half the output clock");

endmodule

// File: testbench/crystal_model.sv
/*
  External crystal model: stable rises a fixed startup time after enable.
  Assumes enable comes from the generator on the same clock.
*/
`timescale 1ns/1ps
module crystal_model #(
    parameter int STARTUP = 20
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic enable,
    output logic      stable
);
    int cnt;
    // startup count, restarted whenever the oscillator is off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) cnt <= 0;
        else if (!enable) cnt <= 0;
        else if (cnt < STARTUP) cnt <= cnt + 1;
    end
    assign stable = (cnt == STARTUP);
endmodule

// File: testbench/test_clock_generator.sv
/*
  Self-checking bench: reset values, external crystal start, low-power
  bypass, PLL engage and output clock enables.
  Assumes the design package and crystal model are compiled first.
*/
`timescale 1ns/1ps
module test_clock_generator;
    logic                  REF_CLK = 0, RSTN = 0, WR = 0, RD = 0, OSC_STABLE;
    logic [3:0]            ADDR = 0;
    logic [7:0]            WDATA = 0, RDATA, d;
    clkgen_pkg::osc_ctrl_s OSC_CTRL;
    clkgen_pkg::mode_e     MODE;
    logic                  GEN_CLK_EN, BUS_CLK_EN;
    int                    err_count = 0, num_checks = 0, g, b;
    logic [7:0]            rst_tab [4] = '{8'h04, 8'h40, 8'h00, 8'h10};

    clock_generator #(.LOCK_CYCLES(8), .SWITCH_CYCLES(2)) u_dut (.REF_CLK(REF_CLK),
        .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .OSC_STABLE(OSC_STABLE), .RDATA(RDATA), .OSC_CTRL(OSC_CTRL), .MODE(MODE),
        .GEN_CLK_EN(GEN_CLK_EN), .BUS_CLK_EN(BUS_CLK_EN));
    crystal_model u_xtal (.clk(REF_CLK), .rst_n(RSTN), .enable(OSC_CTRL.ext_enable),
        .stable(OSC_STABLE));

    // ========================================================================
    // bus and compare helpers
    initial
    begin
        forever #2.5 REF_CLK = ~REF_CLK;
    end
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge REF_CLK);
        ADDR <= a; WDATA <= v; WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge REF_CLK);
        ADDR <= a; RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    // polls status until the masked field matches, then judges it
    task automatic poll(input logic [7:0] m, input logic [7:0] v);
        repeat (300)
        begin
            rd(4'h3);
            if ((d & m) === v) break;
        end
        chk(d & m, v);
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", err_count, num_checks);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ========================================================================
    // scenarios
    task automatic reset_values;
        for (int a = 0; a < 4; a++)
        begin
            rd(a[3:0]);
            chk(d & (a == 3 ? 8'hBF : 8'hFF), rst_tab[a]);
        end
        chk(MODE, clkgen_pkg::FLL_ENGAGED_INTERNAL);
        wr(4'h3, 8'hFF);
        rd(4'h5);
        chk(d, 8'h00);
        rd(4'h3);
        chk(d & 8'hBF, 8'h10);
    endtask
    task automatic to_fbe;
        wr(4'h1, 8'h36);
        poll(8'h02, 8'h02);
        chk({OSC_CTRL.range_high, OSC_CTRL.high_gain, OSC_CTRL.crystal,
             OSC_CTRL.ext_enable}, 4'hF);
        wr(4'h0, 8'hB8);
        poll(8'h1C, 8'h08);
    endtask
    task automatic through_lp_to_pee;
        wr(4'h1, 8'h3E);
        wr(4'h0, 8'h90);
        wr(4'h2, 8'h44);
        repeat (20) @(posedge REF_CLK);
        chk({OSC_CTRL.fll_enable, OSC_CTRL.pll_enable}, 2'b00);
        chk(MODE, clkgen_pkg::LOW_POWER_EXTERNAL_BYPASS);
        rd(4'h3);
        chk(d & 8'h20, 8'h00);
        wr(4'h1, 8'h36);
        poll(8'h20, 8'h20);
        chk(MODE, clkgen_pkg::PLL_BYPASSED_EXTERNAL);
        poll(8'h40, 8'h40);
        chk({OSC_CTRL.ref_div, OSC_CTRL.pll_mult}, 7'h24);
        wr(4'h0, 8'h10);
        rd(4'h3);
        chk(d & 8'h0C, 8'h08);
        poll(8'h0C, 8'h0C);
        chk(MODE, clkgen_pkg::PLL_ENGAGED_EXTERNAL);
    endtask
    // leave pll engaged through external bypass, then down to low power internal
    task automatic pee_to_low_power_internal_bypass;
        wr(4'h0, 8'h90);
        poll(8'h0C, 8'h08);
        chk(MODE, clkgen_pkg::PLL_BYPASSED_EXTERNAL);
        wr(4'h1, 8'h3E);
        wr(4'h0, 8'hB8);
        wr(4'h2, 8'h04);
        wr(4'h1, 8'h36);
        poll(8'h20, 8'h00);
        chk(MODE, clkgen_pkg::FLL_BYPASSED_EXTERNAL);
        poll(8'h40, 8'h40);
        chk(OSC_CTRL.fll_enable, 1'b1);
        wr(4'h0, 8'h44);
        poll(8'h1C, 8'h14);
        chk(MODE, clkgen_pkg::FLL_BYPASSED_INTERNAL);
        wr(4'h1, 8'h08);
        rd(4'h3);
        chk(d & 8'h40, 8'h00);
        chk(MODE, clkgen_pkg::LOW_POWER_INTERNAL_BYPASS);
    endtask
    // low power internal back to fll engaged on the crystal
    task automatic low_power_internal_bypass_to_fee;
        wr(4'h1, 8'h00);
        poll(8'h40, 8'h40);
        chk(MODE, clkgen_pkg::FLL_BYPASSED_INTERNAL);
        wr(4'h1, 8'h36);
        poll(8'h02, 8'h02);
        wr(4'h0, 8'h38);
        poll(8'h1C, 8'h00);
        chk(MODE, clkgen_pkg::FLL_ENGAGED_EXTERNAL);
    endtask
    task automatic clock_enables(input int ng, input int nb);
        g = 0;
        b = 0;
        repeat (40)
        begin
            @(posedge REF_CLK);
            #1 g += GEN_CLK_EN;
            b += BUS_CLK_EN;
        end
        chk(g, ng);
        chk(b, nb);
    endtask

    // ========================================================================
    // main sequence and watchdog
    initial
    begin
        repeat (10) @(posedge REF_CLK);
        RSTN <= 1'b1;
        reset_values();
        clock_enables(20, 10);
        to_fbe();
        through_lp_to_pee();
        pee_to_low_power_internal_bypass();
        low_power_internal_bypass_to_fee();
        clock_enables(40, 20);
        test_done();
    end
    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        err_count++;
        test_done();
    end
endmodule
